// ==== verilog/ccoc_pkg.sv ====
// Register map, field positions and reset values of the comparator output control
package ccoc_pkg;
   // Register data width and byte offsets on the bus
   localparam int unsigned REG_W = 8;
   localparam logic [7:0] OFS_CONTROL_ZERO = 8'h00;
   localparam logic [7:0] OFS_CONTROL_ONE = 8'h04;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
   localparam int unsigned ADDR_DECODE_W = 8;

   // Fields of comparator_control_zero
   localparam int unsigned CZ_ENABLE_BIT = 7;
   localparam int unsigned CZ_OUTPUT_BIT = 6;
   localparam int unsigned CZ_INVERT_BIT = 4;
   localparam int unsigned CZ_HYST_BIT = 1;
   localparam int unsigned CZ_SYNC_BIT = 0;
   localparam logic [7:0] CZ_WRITE_MASK = 8'h93;

   // Fields of comparator_control_one
   localparam int unsigned CO_RISE_BIT = 1;
   localparam int unsigned CO_FALL_BIT = 0;
   localparam logic [7:0] CO_WRITE_MASK = 8'h03;

   // Interrupt status and mask layout
   localparam int unsigned IRQ_FLAG_BIT = 0;
   localparam logic [7:0] IRQ_WRITE_MASK = 8'h01;

   // Reset values
   localparam logic [7:0] CONTROL_ZERO_RST = 8'h00;
   localparam logic [7:0] CONTROL_ONE_RST = 8'h00;
   localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
   localparam logic [7:0] IRQ_MASK_RST = 8'h00;

   // Bus constants
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'h0;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage

// ==== verilog/ccoc_edge.sv ====
// Transition detector on the polarity-adjusted output bit
`timescale 1ns/100ps
module ccoc_edge
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Level in
   input wire logic level_i,
   // Transition pulses
   output logic rise_o,
   output logic fall_o
);
   logic prev;

   // Previous value, so each transition pulses once only
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         prev <= 1'b0;
      else
         prev <= level_i; // R11
   end

   // One-cycle pulses
   assign rise_o = level_i & ~prev; // R11
   assign fall_o = ~level_i & prev; // R11
endmodule // ccoc_edge

// ==== verilog/ccoc_resample.sv ====
// Resampler of the output on falling edges of the timer clock source
`timescale 1ns/100ps
module ccoc_resample
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Timer clock source, sampled as a plain level
   input wire logic tmr_clk_src_i,
   // Timer halted, so no resampling takes place
   input wire logic halt_i,
   // Value to resample and resampled value
   input wire logic d_i,
   output logic q_o
);
   logic tmr_prev;

   // Previous timer clock level for edge finding
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         tmr_prev <= 1'b0;
      else
         tmr_prev <= tmr_clk_src_i;
   end

   // Capture only on a falling edge; a halted timer freezes the value
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         q_o <= 1'b0;
      else if (tmr_prev && !tmr_clk_src_i && !halt_i)
         q_o <= d_i; // R5 R10
   end
endmodule // ccoc_resample

// ==== verilog/ccoc_top.sv ====
// Control, status and interrupt logic for one analog comparator channel
//
// Functional notes
// R1: Inverted polarity: output bit is 1 when positive input below negative.
// R2: Normal polarity: output bit is 1 when positive input above negative.
// R3: Control zero bit 4 inverts the comparator output when set.
// R4: Control zero bit 1 enables comparator hysteresis when set.
// R5: Sync bit 0 set: output resampled on timer clock falling edges.
// R6: Sync bit clear: output to timer and pin follows comparator directly.
// R7: Control one bit 1 sets the flag on each rising output edge.
// R8: Control one bit 0 sets the flag on each falling output edge.
// R9: Control zero bit 7 enables the comparator; cleared means powered down.
// R10: Timer clocked from system clock stops synchronized output during sleep.
// R11: Edge detection uses polarity-adjusted output, flagging each transition once.
//
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module ccoc_top
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   // Analog comparator core
   input wire logic cmp_raw_i,
   output logic cmp_enable_o,
   output logic hysteresis_enable_o,
   // Timer clock source and power state
   input wire logic tmr_clk_src_i,
   input wire logic sleep_i,
   input wire logic tmr_src_halts_i,
   // Output to timer and pin
   output logic cmp_out_o,
   // Interrupt
   output logic irq_o
);
   localparam int unsigned W = ccoc_pkg::REG_W;

   // Registers
   logic [W-1:0] control_zero;
   logic [W-1:0] control_one;
   logic [W-1:0] irq_status;
   logic [W-1:0] irq_mask;

   // Bus data phase state
   logic wr_pending;
   logic [ccoc_pkg::ADDR_DECODE_W-1:0] wr_addr;

   // Datapath
   logic comparator_on;
   logic channel_output_invert;
   logic channel_output_bit;
   logic sync_mode;
   logic timer_halted;
   logic resampled;
   logic out_rise;
   logic out_fall;
   logic flag_set;
   logic flag_clear;
   logic addr_phase;
   logic [W-1:0] read_value;
   logic [W-1:0] next_irq_status;

   // Control field decode
   assign comparator_on = control_zero[ccoc_pkg::CZ_ENABLE_BIT];
   assign channel_output_invert = control_zero[ccoc_pkg::CZ_INVERT_BIT];
   assign sync_mode = control_zero[ccoc_pkg::CZ_SYNC_BIT];

   // Core power and hysteresis controls
   assign cmp_enable_o = comparator_on; // R9
   assign hysteresis_enable_o = control_zero[ccoc_pkg::CZ_HYST_BIT]; // R4

   // Polarity; raw is 1 when positive above negative. Off core reads low.
   assign channel_output_bit = comparator_on & (cmp_raw_i ^ channel_output_invert); // R1 R2 R3

   // Timer halts in sleep when clocked from the system or instruction clock
   assign timer_halted = sleep_i & tmr_src_halts_i; // R10

   // Resampled copy for synchronous mode
   ccoc_resample u_resample
   (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .tmr_clk_src_i(tmr_clk_src_i),
      .halt_i(timer_halted),
      .d_i(channel_output_bit),
      .q_o(resampled)
   );

   // Asynchronous mode passes straight through, no register in the path
   assign cmp_out_o = sync_mode ? resampled : channel_output_bit; // R5 R6

   // Transitions of the polarity-adjusted output bit
   ccoc_edge u_edge
   (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .level_i(channel_output_bit),
      .rise_o(out_rise),
      .fall_o(out_fall)
   );

   // Flag events gated by their edge enables
   assign flag_set = (out_rise & control_one[ccoc_pkg::CO_RISE_BIT]) // R7
      | (out_fall & control_one[ccoc_pkg::CO_FALL_BIT]); // R8

   // Bus accepts a transfer in its address phase
   assign addr_phase = hsel_i & hready_i & (htrans_i == ccoc_pkg::HTRANS_NONSEQ);

   // No wait states; errors never reported
   assign hreadyout_o = 1'b1;
   assign hresp_o = ccoc_pkg::HRESP_OKAY;

   // Capture write address for the following data phase
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_pending <= 1'b0;
         wr_addr <= '0;
      end
      else if (hready_i)
      begin
         wr_pending <= addr_phase & hwrite_i;
         wr_addr <= haddr_i[ccoc_pkg::ADDR_DECODE_W-1:0];
      end
   end

   // Control register zero; output bit is live status, not stored
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         control_zero <= ccoc_pkg::CONTROL_ZERO_RST;
      else if (wr_pending && wr_addr == ccoc_pkg::OFS_CONTROL_ZERO)
         control_zero <= hwdata_i[W-1:0] & ccoc_pkg::CZ_WRITE_MASK; // R3 R4 R9
   end

   // Control register one, edge enables
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         control_one <= ccoc_pkg::CONTROL_ONE_RST;
      else if (wr_pending && wr_addr == ccoc_pkg::OFS_CONTROL_ONE)
         control_one <= hwdata_i[W-1:0] & ccoc_pkg::CO_WRITE_MASK; // R7 R8
   end

   // Interrupt mask
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         irq_mask <= ccoc_pkg::IRQ_MASK_RST;
      else if (wr_pending && wr_addr == ccoc_pkg::OFS_IRQ_MASK)
         irq_mask <= hwdata_i[W-1:0] & ccoc_pkg::IRQ_WRITE_MASK;
   end

   // Write-one-to-clear on the flag
   assign flag_clear = wr_pending && wr_addr == ccoc_pkg::OFS_IRQ_STATUS
      && hwdata_i[ccoc_pkg::IRQ_FLAG_BIT];

   // Sticky flag; a new event in the clear cycle wins
   always_comb
   begin
      next_irq_status = irq_status;
      if (flag_clear)
         next_irq_status[ccoc_pkg::IRQ_FLAG_BIT] = 1'b0;
      if (flag_set)
         next_irq_status[ccoc_pkg::IRQ_FLAG_BIT] = 1'b1; // R7 R8
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         irq_status <= ccoc_pkg::IRQ_STATUS_RST;
      else
         irq_status <= next_irq_status;
   end

   // Level interrupt while any unmasked flag stands
   assign irq_o = |(irq_status & irq_mask);

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      read_value = '0;
      case (haddr_i[ccoc_pkg::ADDR_DECODE_W-1:0])
         ccoc_pkg::OFS_CONTROL_ZERO:
         begin
            read_value = control_zero;
            read_value[ccoc_pkg::CZ_OUTPUT_BIT] = channel_output_bit; // R1 R2
         end
         ccoc_pkg::OFS_CONTROL_ONE: read_value = control_one;
         ccoc_pkg::OFS_IRQ_STATUS: read_value = irq_status;
         ccoc_pkg::OFS_IRQ_MASK: read_value = irq_mask;
         default: read_value = '0;
      endcase
   end

   // Read data sampled at the address phase, shown through the data phase
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         hrdata_o <= ccoc_pkg::RDATA_ZERO;
      else if (addr_phase && !hwrite_i)
         hrdata_o <= {{(32 - W){1'b0}}, read_value};
   end
endmodule // ccoc_top

// ==== test/ccoc_core_model.sv ====
// Model of the analog comparator core and the timer clock source
`timescale 1ns/100ps
module ccoc_core_model
(
   // Clock
   input wire logic clk_i,
   // Analog inputs as numbers, core controls
   input wire logic [7:0] pos_i,
   input wire logic [7:0] neg_i,
   input wire logic en_i,
   input wire logic hyst_i,
   // Core result and timer clock source
   output logic raw_o = 1'b0,
   output logic tmr_o = 1'b0
);
   logic [1:0] div = 2'h0;
   // Core decision; hysteresis holds the result inside a band of 2
   always @(posedge clk_i)
   begin
      if (!en_i)
         raw_o <= !raw_o;
      else if (!hyst_i || pos_i > neg_i + 8'h02 || pos_i + 8'h02 < neg_i)
         raw_o <= pos_i > neg_i;
   end
   // Timer source of 8 cycles; runs on in sleep so only the design's halt can freeze
   always @(posedge clk_i)
   begin
      div <= div + 2'h1;
      if (div == 2'h3)
         tmr_o <= !tmr_o;
   end
endmodule // ccoc_core_model

// ==== test/ccoc_top_sva.sv ====
// Port assertions of the comparator output control
`timescale 1ns/100ps
module ccoc_top_sva
(
   // Watched ports
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic [31:0] hrdata_o,
   input wire logic cmp_raw_i,
   input wire logic cmp_enable_o,
   input wire logic hysteresis_enable_o,
   input wire logic tmr_clk_src_i,
   input wire logic cmp_out_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Bus side: no waits, no errors, narrow read data held between reads
   property p_bus; hreadyout_o && !hresp_o; endproperty
   property p_rd_hi; hrdata_o[31:8] == 24'h0; endproperty
   property p_rd_hold;
      $changed(hrdata_o) |-> $past(htrans_i) == ccoc_pkg::HTRANS_NONSEQ && !$past(hwrite_i);
   endproperty
   // Output moves only on input change, timer falling edge or a write
   property p_out;
      $changed(cmp_out_o) |-> $changed(cmp_raw_i) || $past(hwrite_i, 2)
         || ($past(tmr_clk_src_i, 2) && !$past(tmr_clk_src_i));
   endproperty
   property p_irq_up;
      $rose(irq_o) |-> $past(cmp_raw_i) != $past(cmp_raw_i, 2) || $past(hwrite_i, 2);
   endproperty
   property p_irq_dn; $fell(irq_o) |-> $past(hwrite_i, 2); endproperty
   property p_hyst_en; $changed(hysteresis_enable_o) |-> $past(hwrite_i, 2); endproperty
   property p_en; $changed(cmp_enable_o) |-> $past(hwrite_i, 2); endproperty
   a_bus: assert property (p_bus) else $error("bus wait or error");
   a_rd_hi: assert property (p_rd_hi) else $error("read data upper bits set");
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   a_out: assert property (p_out) else $error("output moved without cause");
   a_irq_up: assert property (p_irq_up) else $error("irq rose without cause");
   a_irq_dn: assert property (p_irq_dn) else $error("irq fell without write");
   a_hyst_en: assert property (p_hyst_en) else $error("hysteresis moved");
   a_en: assert property (p_en) else $error("enable moved");
   c_irq: cover property ($rose(irq_o));
   c_sync: cover property ($changed(cmp_out_o) && !$changed(cmp_raw_i));
   c_en: cover property ($rose(cmp_enable_o));
endmodule // ccoc_top_sva
bind ccoc_top ccoc_top_sva i_ccoc_top_sva (.clk_i, .rst_n_i, .htrans_i, .hwrite_i,
   .hreadyout_o, .hresp_o, .hrdata_o, .cmp_raw_i, .cmp_enable_o, .hysteresis_enable_o,
   .tmr_clk_src_i, .cmp_out_o, .irq_o);

// ==== test/ccoc_top_tb.sv ====
// Self-checking bench of the comparator output control
`timescale 1ns/100ps
module ccoc_top_tb;
   logic clk_i = 1'b0, rst_n_i = 1'b0, hsel = 1'b0, hwrite = 1'b0, sleep = 1'b0;
   logic halts = 1'b0, iv = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
   logic [7:0] pos = 8'h00, neg = 8'h00, v;
   wire logic hready, hresp, raw, en, hyst_en, tmr, out, irq;
   int error_cnt = 0, check_count = 0, seed = 32'hbc3b;
   // Clock of 5 ns
   always #2.5 clk_i = ~clk_i;
   ccoc_top i_ccoc_top (.clk_i, .rst_n_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
      .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .cmp_raw_i(raw),
      .cmp_enable_o(en), .hysteresis_enable_o(hyst_en), .tmr_clk_src_i(tmr), .sleep_i(sleep),
      .tmr_src_halts_i(halts), .cmp_out_o(out), .irq_o(irq));
   ccoc_core_model i_ccoc_core_model (.clk_i, .pos_i(pos),
      .neg_i(neg), .en_i(en), .hyst_i(hyst_en), .raw_o(raw), .tmr_o(tmr));
   function automatic logic exp_out(logic e, logic i, logic r);
      return e & (r ^ i);
   endfunction
   // Flag expected from the edge of the polarity-adjusted bit
   function automatic logic exp_flag(logic [1:0] c, logic i, logic up);
      return (up ^ i) ? c[1] : c[0];
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // One AHB single transfer; waits for hready without assuming a count
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      haddr <= {24'h0, a};
      htrans <= ccoc_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge clk_i); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge clk_i); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      check(rd, {24'h0, e});
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog against a hung handshake
   initial
   begin
      #200000;
      error_cnt++;
      conclude();
   end
   // Main sequence
   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      hsel <= 1'b1;
      for (int a = 0; a < 20; a += 4)
         rchk(a[7:0], 8'h00);
      // Random polarity, enable and hysteresis in the direct output mode
      for (int i = 0; i < 40; i++)
      begin
         v = 8'($random(seed)) & ccoc_pkg::CZ_WRITE_MASK & 8'hFE;
         pos <= 8'($random(seed)) & 8'h7F;
         neg <= 8'($random(seed)) & 8'h7F;
         bus(1'b1, ccoc_pkg::OFS_CONTROL_ZERO, v);
         cyc(3);
         check(hyst_en, v[1]);
         check(en, v[7]);
         check(out, exp_out(v[7], v[4], raw));
         rchk(ccoc_pkg::OFS_CONTROL_ZERO, v | {exp_out(v[7], v[4], raw), 6'h0});
      end
      // Every edge enable setting against both edges, random polarity
      bus(1'b1, ccoc_pkg::OFS_IRQ_MASK, 8'h01);
      for (int c = 0; c < 4; c++)
      begin
         iv = 1'($random(seed));
         pos <= 8'h00;
         neg <= 8'h64;
         bus(1'b1, ccoc_pkg::OFS_CONTROL_ONE, c[7:0]);
         bus(1'b1, ccoc_pkg::OFS_CONTROL_ZERO, {3'h4, iv, 4'h0});
         cyc(3);
         bus(1'b1, ccoc_pkg::OFS_IRQ_STATUS, 8'h01);
         pos <= 8'h64 + 8'h64;
         cyc(4);
         check(irq, exp_flag(c[1:0], iv, 1'b1));
         rchk(ccoc_pkg::OFS_IRQ_STATUS, {7'h0, exp_flag(c[1:0], iv, 1'b1)});
         bus(1'b1, ccoc_pkg::OFS_IRQ_STATUS, 8'h01);
         pos <= 8'h00;
         cyc(4);
         check(irq, exp_flag(c[1:0], iv, 1'b0));
      end
      // Mask gates the pending flag; write one clears it
      bus(1'b1, ccoc_pkg::OFS_IRQ_MASK, 8'h00);
      cyc(1);
      check(irq, 1'b0);
      bus(1'b1, ccoc_pkg::OFS_IRQ_MASK, 8'h01);
      cyc(1);
      check(irq, 1'b1);
      bus(1'b1, ccoc_pkg::OFS_IRQ_STATUS, 8'h01);
      cyc(1);
      check(irq, 1'b0);
      // Resampled output: change while timer high, seen only after its fall
      bus(1'b1, ccoc_pkg::OFS_CONTROL_ZERO, 8'h81);
      cyc(20);
      check(out, 1'b0);
      while (tmr !== 1'b0) @(posedge clk_i);
      while (tmr !== 1'b1) @(posedge clk_i);
      pos <= 8'hC8;
      cyc(2);
      check(out, 1'b0);
      cyc(8);
      check(out, 1'b1);
      sleep <= 1'b1;
      halts <= 1'b1;
      pos <= 8'h00;
      cyc(20);
      check(out, 1'b1);
      // Still asleep, but a source that keeps running lets resampling go on
      halts <= 1'b0;
      cyc(20);
      check(out, 1'b0);
      conclude();
   end
endmodule // ccoc_top_tb
